// ### shared/packer_pkg.sv
// Constants, register map and carrier types of the serial-to-network packer.
// Assumes a 100 MHz clock and a one-cycle plain register port.
package packer_pkg;
   localparam int CLOCK_NS = 10;
   localparam int MS_NS = 1_000_000;
   localparam int MS_CYCLES_DEF = MS_NS / CLOCK_NS;
   localparam int MIN_MS = 60000;
   localparam int HOSTS = 4;
   localparam int BUF_BYTES = 1024;
   localparam int FIFO_DEPTH = 4;
   // Register byte offsets.
   localparam logic [7:0] REG_DELIM = 8'h00;
   localparam logic [7:0] REG_FORCE = 8'h04;
   localparam logic [7:0] REG_IDLE = 8'h08;
   localparam logic [7:0] REG_MAXCONN = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   // Reset values and limits.
   localparam logic [6:0] IDLE_DEF = 7'h07;
   localparam logic [6:0] IDLE_MAX = 7'h63;
   localparam logic [2:0] MAXCONN_DEF = 3'h1;
   localparam logic [2:0] MAXCONN_TOP = 3'h4;
   localparam logic [7:0] NO_DELIM = 8'h00;
   localparam logic [15:0] FORCE_OFF = 16'h0000;
   localparam logic [10:0] BUF_FULL = 11'h400;
   // Status field positions.
   localparam int ST_ACTIVE = 16;
   localparam int ST_SUSPEND = 20;
   localparam int ST_DRAIN = 21;
   typedef enum logic [1:0] {COLLECT = 2'b01, DRAIN = 2'b10} pack_state_type;
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] address;
      logic [31:0] writeData;
   } reg_request_type;
   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } packet_beat_type;
endpackage

// ### design/serial_to_network_packer.sv
// Serial-to-network packer: delimiter, buffer-full and idle-timeout packing,
// host connection policy and network-to-serial forwarding for one port.
// Assumes synchronous inputs, one 100 MHz clock and a one-cycle register port.
//
// Functional notes
// - Idle-link timeout of zero minutes never closes a connection.
// - Timeout 1 to 99 minutes closes an idle connection, then accepts anew.
// - Maximum connections is 1 to 4, default 1.
// - With one connection allowed, that host gets full port control.
// - With 2 to 4 allowed, that many hosts share a plain data path.
// - Network data reaches the serial port in arrival order.
// - With several connections, a closing host halts serial traffic for all until the close completes.
// - With several connections, local line parameters apply, not host ones.
// - Each delimiter is one byte; zero means unused, the default.
// - With no delimiter, every serial byte is sent at once.
// - With delimiters, bytes buffer until the delimiter or pair, then send.
// - A full 1K buffer is packed and emptied.
// - Force-transmit of zero disables the idle packing timer.
// - Force-transmit of 1 to 65535 ms packs the buffer after that idle time.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps

// Small FIFO with valid and ready on both sides.
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] fill;
   logic push;
   logic pop;

   // Handshakes and honest full and empty.
   assign inReady = fill != (AW+1)'(DEPTH);
   assign outValid = fill != '0;
   assign outData = store[rdPtr];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   // Storage is written without reset.
   always_ff @(posedge clock) begin
      if (push) begin
         store[wrPtr] <= inData;
      end
   end

   // Pointers wrap at the depth.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         fill <= '0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : AW'(wrPtr + 1'b1);
         end
         if (pop) begin
            rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : AW'(rdPtr + 1'b1);
         end
         fill <= (AW+1)'(fill + push - pop);
      end
   end
endmodule

module serial_to_network_packer #(
   parameter int MS_CYCLES = packer_pkg::MS_CYCLES_DEF
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire packer_pkg::reg_request_type request,
   output logic [31:0] readData,
   input wire logic serRxValid,
   output logic serRxReady,
   input wire logic [7:0] serRxData,
   output packer_pkg::packet_beat_type packet,
   input wire logic packetReady,
   input wire logic netRxValid,
   output logic netRxReady,
   input wire logic [7:0] netRxData,
   output logic serTxValid,
   output logic [7:0] serTxData,
   input wire logic serTxReady,
   input wire logic [packer_pkg::HOSTS-1:0] hostOpen,
   input wire logic [packer_pkg::HOSTS-1:0] hostClose,
   input wire logic [packer_pkg::HOSTS-1:0] hostCloseDone,
   input wire logic [packer_pkg::HOSTS-1:0] hostActivity,
   output logic [packer_pkg::HOSTS-1:0] connActive,
   output logic [packer_pkg::HOSTS-1:0] dropLink,
   output logic fullControl,
   output logic localParams
);
   import packer_pkg::*;

   typedef struct packed {
      pack_state_type state;
      logic [10:0] count;
      logic [10:0] rdIdx;
      logic lastD1;
      logic [15:0] forceMs;
      packet_beat_type packet;
      logic [16:0] msCount;
      logic msTick;
      logic [HOSTS-1:0] active;
      logic [HOSTS-1:0] closing;
      logic suspend;
      logic [HOSTS-1:0][22:0] linkMs;
      logic [HOSTS-1:0] drop;
      logic fullControl;
      logic localParams;
      logic serTxValid;
      logic [7:0] serTxData;
      logic [7:0] delim1;
      logic [7:0] delim2;
      logic [15:0] forceTx;
      logic [6:0] idleMin;
      logic [2:0] maxConn;
      logic [31:0] readData;
   } state_type;

   state_type s;
   state_type next_s;
   logic [7:0] buffer [BUF_BYTES];
   logic rxValid;
   logic [7:0] rxByte;
   logic rxPop;
   logic rxInReady;
   logic txValid;
   logic [7:0] txByte;
   logic txPop;
   logic memWrite;
   logic [22:0] idleLimit;

   // Serial bytes wait in a FIFO; the packer stalls it while draining.
   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
      .clock(clock),
      .reset_n(reset_n),
      .inValid(serRxValid & ~s.suspend),
      .inReady(rxInReady),
      .inData(serRxData),
      .outValid(rxValid),
      .outReady(rxPop),
      .outData(rxByte)
   );

   // Network bytes keep their arrival order on the way to the serial port.
   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txFifo (
      .clock(clock),
      .reset_n(reset_n),
      .inValid(netRxValid),
      .inReady(netRxReady),
      .inData(netRxData),
      .outValid(txValid),
      .outReady(txPop),
      .outData(txByte)
   );

   assign serRxReady = rxInReady & ~s.suspend;
   assign rxPop = (s.state == COLLECT) && rxValid && !s.suspend;
   assign memWrite = rxPop;
   assign txPop = txValid && !s.suspend && (!s.serTxValid || serTxReady);
   assign idleLimit = 23'(s.idleMin * MIN_MS);

   // Frame buffer of 1K bytes.
   always_ff @(posedge clock) begin
      if (memWrite) begin
         buffer[s.count[9:0]] <= rxByte;
      end
   end

   function automatic logic [2:0] countActive(input logic [HOSTS-1:0] v);
      logic [2:0] n;
      n = '0;
      for (int k = 0; k < HOSTS; k++) begin
         n = 3'(n + v[k]);
      end
      return n;
   endfunction

   // Next state of registers, packer, timers and connections.
   always_comb begin
      logic hit;
      logic [10:0] nextCount;
      logic [2:0] used;
      hit = 1'b0;
      nextCount = '0;
      used = '0;
      next_s = s;
      next_s.drop = '0;
      next_s.readData = '0;
      // Register writes; out-of-range idle-timeout and connection-count values leave the setting unchanged.
      if (request.write) begin
         unique case (request.address)
            REG_DELIM: begin
               next_s.delim1 = request.writeData[7:0];
               next_s.delim2 = request.writeData[15:8];
            end
            REG_FORCE: next_s.forceTx = request.writeData[15:0];
            REG_IDLE: begin
               if (request.writeData[6:0] <= IDLE_MAX && request.writeData[31:7] == '0) begin
                  next_s.idleMin = request.writeData[6:0];
               end
            end
            REG_MAXCONN: begin
               if (request.writeData[2:0] != '0 && request.writeData[2:0] <= MAXCONN_TOP
                   && request.writeData[31:3] == '0) begin
                  next_s.maxConn = request.writeData[2:0];
               end
            end
            default: begin
            end
         endcase
      end
      // Register reads answer in the next cycle; unmapped reads give zero.
      if (request.read) begin
         unique case (request.address)
            REG_DELIM: next_s.readData = {16'h0000, s.delim2, s.delim1};
            REG_FORCE: next_s.readData = {16'h0000, s.forceTx};
            REG_IDLE: next_s.readData = {25'h000_0000, s.idleMin};
            REG_MAXCONN: next_s.readData = {29'h0000_0000, s.maxConn};
            REG_STATUS: begin
               next_s.readData[10:0] = s.count;
               next_s.readData[ST_ACTIVE +: HOSTS] = s.active;
               next_s.readData[ST_SUSPEND] = s.suspend;
               next_s.readData[ST_DRAIN] = s.state == DRAIN;
            end
            default: next_s.readData = '0;
         endcase
      end
      // Millisecond timebase.
      next_s.msTick = 1'b0;
      if (s.msCount == 17'(MS_CYCLES - 1)) begin
         next_s.msCount = '0;
         next_s.msTick = 1'b1;
      end else begin
         next_s.msCount = 17'(s.msCount + 1'b1);
      end
      // Force timer restarts on each arriving serial byte.
      if (serRxValid && serRxReady) begin
         next_s.forceMs = '0;
      end else if (s.msTick && s.forceMs != '1) begin
         next_s.forceMs = 16'(s.forceMs + 1'b1);
      end
      // Packer.
      unique case (s.state)
         COLLECT: begin
            if (rxPop) begin
               nextCount = 11'(s.count + 1'b1);
               next_s.count = nextCount;
               next_s.lastD1 = rxByte == s.delim1;
               if (s.delim1 == NO_DELIM && s.delim2 == NO_DELIM) begin
                  hit = 1'b1;
               end else if (s.delim2 == NO_DELIM) begin
                  hit = rxByte == s.delim1;
               end else if (s.delim1 != NO_DELIM) begin
                  hit = s.lastD1 && rxByte == s.delim2;
               end
               if (hit || nextCount == BUF_FULL) begin
                  next_s.state = DRAIN;
                  next_s.rdIdx = '0;
               end
            end else if (s.count != '0 && s.forceTx != FORCE_OFF && s.forceMs >= s.forceTx) begin
               next_s.state = DRAIN;
               next_s.rdIdx = '0;
            end
         end
         DRAIN: begin
            if (!s.packet.valid || packetReady) begin
               if (s.rdIdx < s.count) begin
                  next_s.packet.valid = 1'b1;
                  next_s.packet.data = buffer[s.rdIdx[9:0]];
                  next_s.packet.last = s.rdIdx == 11'(s.count - 1'b1);
                  next_s.rdIdx = 11'(s.rdIdx + 1'b1);
               end else begin
                  next_s.packet.valid = 1'b0;
                  next_s.packet.last = 1'b0;
                  next_s.state = COLLECT;
                  next_s.count = '0;
                  next_s.lastD1 = 1'b0;
               end
            end
         end
      endcase
      // Serial output stage, held while a close is pending.
      if (txPop) begin
         next_s.serTxValid = 1'b1;
         next_s.serTxData = txByte;
      end else if (serTxReady) begin
         next_s.serTxValid = 1'b0;
      end
      // Connections: idle timers, closes and opens.
      for (int i = 0; i < HOSTS; i++) begin
         if (hostActivity[i] || !s.active[i]) begin
            next_s.linkMs[i] = '0;
         end else if (s.msTick) begin
            next_s.linkMs[i] = 23'(s.linkMs[i] + 1'b1);
         end
         if (s.active[i] && s.idleMin != '0 && s.linkMs[i] >= idleLimit) begin
            next_s.drop[i] = 1'b1;
            next_s.active[i] = 1'b0;
            next_s.linkMs[i] = '0;
         end
         if (hostCloseDone[i]) begin
            next_s.active[i] = 1'b0;
            next_s.closing[i] = 1'b0;
         end
         if (hostClose[i] && s.active[i] && s.maxConn > MAXCONN_DEF) begin
            next_s.closing[i] = 1'b1;
         end
      end
      used = countActive(next_s.active);
      for (int i = 0; i < HOSTS; i++) begin
         if (hostOpen[i] && !next_s.active[i] && !next_s.drop[i] && used < s.maxConn) begin
            next_s.active[i] = 1'b1;
            used = 3'(used + 1'b1);
         end
      end
      next_s.suspend = |next_s.closing;
      next_s.fullControl = s.maxConn == MAXCONN_DEF && |s.active;
      next_s.localParams = s.maxConn > MAXCONN_DEF;
   end

   // State register.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.state <= COLLECT;
         s.idleMin <= IDLE_DEF;
         s.maxConn <= MAXCONN_DEF;
      end else begin
         s <= next_s;
      end
   end

   // Outputs come straight from the state register.
   assign readData = s.readData;
   assign packet = s.packet;
   assign serTxValid = s.serTxValid;
   assign serTxData = s.serTxData;
   assign connActive = s.active;
   assign dropLink = s.drop;
   assign fullControl = s.fullControl;
   assign localParams = s.localParams;

   // Checks of the packing and connection policy.
   sequence firstDelim;
      rxPop && s.delim1 != NO_DELIM && s.delim2 != NO_DELIM && rxByte == s.delim1;
   endsequence
   sequence secondDelim;
      rxPop && rxByte == s.delim2;
   endsequence

   a_pair_packs: assert property (@(posedge clock) disable iff (!reset_n)
      firstDelim ##1 secondDelim |=> s.state == DRAIN)
      else $error("Delimiter pair did not start a frame.");
   a_nodelim_sends: assert property (@(posedge clock) disable iff (!reset_n)
      rxPop && s.delim1 == NO_DELIM && s.delim2 == NO_DELIM |=> s.state == DRAIN ##1 s.packet.valid)
      else $error("Byte was held with no delimiter set.");
   a_full_packs: assert property (@(posedge clock) disable iff (!reset_n)
      rxPop && s.count == 11'(BUF_FULL - 1'b1) |=> s.state == DRAIN)
      else $error("Full buffer was not packed.");
   a_force_off: assert property (@(posedge clock) disable iff (!reset_n)
      s.state == COLLECT && !rxPop && s.forceTx == FORCE_OFF |=> s.state == COLLECT)
      else $error("Frame sent with force timer off.");
   a_force_fires: assert property (@(posedge clock) disable iff (!reset_n)
      s.state == COLLECT && !rxPop && s.count != '0 && s.forceTx != FORCE_OFF && s.forceMs >= s.forceTx
      |=> s.state == DRAIN)
      else $error("Idle buffer not packed after force time.");
   a_idle_never: assert property (@(posedge clock) disable iff (!reset_n)
      $past(s.idleMin) == '0 |-> s.drop == '0)
      else $error("Link dropped with idle timeout off.");
   a_idle_drop: assert property (@(posedge clock) disable iff (!reset_n)
      s.drop != '0 |-> (s.drop & s.active) == '0 && $past(s.idleMin) != '0)
      else $error("Dropped link still active.");
   a_conn_limit: assert property (@(posedge clock) disable iff (!reset_n)
      (s.active & ~$past(s.active)) != '0 |-> countActive(s.active) <= $past(s.maxConn))
      else $error("Too many host connections.");
   a_full_control: assert property (@(posedge clock) disable iff (!reset_n)
      ##1 s.fullControl == ($past(s.maxConn) == MAXCONN_DEF && |$past(s.active)))
      else $error("Port control does not follow single connection.");
   a_local_params: assert property (@(posedge clock) disable iff (!reset_n)
      s.maxConn > MAXCONN_DEF ##1 s.maxConn > MAXCONN_DEF |-> s.localParams)
      else $error("Host parameters used with several connections.");
   a_close_halts: assert property (@(posedge clock) disable iff (!reset_n)
      (hostClose & s.active) != '0 && s.maxConn > MAXCONN_DEF |=> s.suspend && !serRxReady && !txPop)
      else $error("Serial traffic during a pending close.");
endmodule

// ### verif/network_partner.sv
// Far-side model: network sink for frame beats and serial transmitter for bytes.
// Assumes it shares the packer's clock; mode comes from the bench.
`timescale 1ns/100ps
module network_partner
import packer_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire packer_pkg::packet_beat_type packet,
   input wire logic serTxValid,
   input wire logic [7:0] serTxData,
   input wire logic [1:0] mode,
   output logic packetReady,
   output logic serTxReady
);
   logic [7:0] frameBytes[$];
   logic frameLast[$];
   logic [7:0] txBytes[$];
   logic phase;
   // Phase toggles so mode 1 takes a beat only every other cycle, a slow taker.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         phase <= 1'b0;
      end else begin
         phase <= ~phase;
      end
   end
   // Mode 2 stops the serial transmitter entirely.
   assign packetReady = !(mode == 2'h1 && phase);
   assign serTxReady = mode == 2'h0 || (mode == 2'h1 && phase);
   // Every beat and byte is recorded at the edge that takes it.
   always @(posedge clock) begin
      if (packet.valid && packetReady) begin
         frameBytes.push_back(packet.data);
         frameLast.push_back(packet.last);
      end
      if (serTxValid && serTxReady) begin
         txBytes.push_back(serTxData);
      end
   end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the serial-to-network packer.
// Assumes the packer package and the partner model are compiled first.
`timescale 1ns/100ps
module testbench;
import packer_pkg::*;
   localparam int MSC = 1;
   typedef struct {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} row_type;
   logic clock, reset_n, serRxValid, serRxReady, packetReady, netRxValid, netRxReady;
   logic serTxValid, serTxReady, fullControl, localParams;
   logic [7:0] serRxData, netRxData, serTxData;
   logic [31:0] readData, rd;
   logic [15:0] hostPulse;
   logic [3:0] connActive, dropLink;
   logic [1:0] partnerMode;
   reg_request_type request;
   packet_beat_type packet;
   int errTotal, nCompared, k;
   logic took;
   logic [7:0] q[$];
   row_type rows[14] = '{'{0, REG_IDLE, 8'h00, 8'h07}, '{0, REG_MAXCONN, 8'h00, 8'h01},
      '{0, REG_DELIM, 8'h00, 8'h00}, '{0, REG_FORCE, 8'h00, 8'h00}, '{0, 8'h14, 8'h00, 8'h00},
      '{1, REG_IDLE, 8'h64, 8'h00}, '{0, REG_IDLE, 8'h00, 8'h07}, '{1, REG_MAXCONN, 8'h00, 8'h00},
      '{0, REG_MAXCONN, 8'h00, 8'h01}, '{1, REG_MAXCONN, 8'h05, 8'h00}, '{0, REG_MAXCONN, 8'h00, 8'h01},
      '{1, 8'h14, 8'hFF, 8'h00}, '{0, 8'h14, 8'h00, 8'h00}, '{0, REG_IDLE, 8'h00, 8'h07}};

   serial_to_network_packer #(.MS_CYCLES(MSC)) i_serial_to_network_packer (.clock(clock), .reset_n(reset_n),
      .request(request), .readData(readData), .serRxValid(serRxValid), .serRxReady(serRxReady),
      .serRxData(serRxData), .packet(packet), .packetReady(packetReady), .netRxValid(netRxValid),
      .netRxReady(netRxReady), .netRxData(netRxData), .serTxValid(serTxValid), .serTxData(serTxData),
      .serTxReady(serTxReady), .hostOpen(hostPulse[3:0]), .hostClose(hostPulse[7:4]),
      .hostCloseDone(hostPulse[11:8]), .hostActivity(hostPulse[15:12]), .connActive(connActive),
      .dropLink(dropLink), .fullControl(fullControl), .localParams(localParams));
   network_partner i_network_partner (.clock(clock), .reset_n(reset_n), .packet(packet),
      .serTxValid(serTxValid), .serTxData(serTxData), .mode(partnerMode), .packetReady(packetReady),
      .serTxReady(serTxReady));

   // Free-running 100 MHz clock.
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      nCompared++;
      if (got !== exp) begin
         errTotal++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One register cycle; read data are taken in the cycle after the strobe.
   task automatic regOp(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      request <= '{write: wr, read: !wr, address: a, writeData: d};
      @(posedge clock);
      request <= '0;
      #1;
      rd = readData;
   endtask

   // Serial bytes offered back to back, each held until it is taken.
   task automatic sendSer(input logic [7:0] b[$]);
      logic ok;
      foreach (b[i]) begin
         serRxValid <= 1'b1;
         serRxData <= b[i];
         // Ready is read settled inside the cycle, as the packer sees it at the next edge.
         do begin
            #1;
            ok = serRxReady;
            @(posedge clock);
         end while (ok !== 1'b1);
      end
      serRxValid <= 1'b0;
   endtask

   // Host event pulse: kind 0 open, 1 close, 2 close done, 3 activity.
   task automatic pulse(input int kind, input logic [3:0] m);
      @(posedge clock);
      hostPulse <= 16'(m) << (4 * kind);
      @(posedge clock);
      hostPulse <= '0;
      repeat (2) @(posedge clock);
      #1;
   endtask

   // Waits for a whole frame at the partner and compares bytes and end mark.
   task automatic expectFrame(input logic [7:0] b[$], input string what);
      int n;
      n = 0;
      while (i_network_partner.frameBytes.size() < b.size() && n < 5000) begin
         @(posedge clock);
         n++;
      end
      repeat (4) @(posedge clock);
      check(32'(i_network_partner.frameBytes.size()), 32'(b.size()), what);
      if (i_network_partner.frameBytes.size() == b.size()) begin
         foreach (b[i]) check({i_network_partner.frameLast[i], i_network_partner.frameBytes[i]},
            {i == b.size() - 1, b[i]}, what);
      end
      i_network_partner.frameBytes.delete();
      i_network_partner.frameLast.delete();
   endtask

   task automatic wrapUp();
      $display("Comparisons %0d, mismatches %0d", nCompared, errTotal);
      if (errTotal == 0 && nCompared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Cuts a hang short well after the expected run of some 63000 cycles.
   initial begin
      #1_000_000;
      errTotal++;
      wrapUp();
   end

   // Main sequence: reset, register table, then the hand-written cases.
   initial begin
      reset_n = 1'b0;
      request = '0;
      serRxValid = 1'b0;
      serRxData = 8'h00;
      netRxValid = 1'b0;
      netRxData = 8'h00;
      hostPulse = '0;
      partnerMode = 2'h0;
      errTotal = 0;
      nCompared = 0;
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      foreach (rows[i]) begin
         regOp(rows[i].wr, rows[i].addr, 32'(rows[i].data));
         if (!rows[i].wr) check(rd, 32'(rows[i].exp), "register row");
      end
      sendSer('{8'h41});
      expectFrame('{8'h41}, "byte sent at once");
      regOp(1, REG_DELIM, 32'h0000_000A);
      sendSer('{8'h41, 8'h42, 8'h0A});
      expectFrame('{8'h41, 8'h42, 8'h0A}, "single delimiter");
      regOp(1, REG_DELIM, 32'h0000_0A0D);
      sendSer('{8'h0D, 8'h41, 8'h0D, 8'h0A});
      expectFrame('{8'h0D, 8'h41, 8'h0D, 8'h0A}, "delimiter pair");
      regOp(1, REG_DELIM, 32'h0000_000A);
      sendSer('{8'h55});
      repeat (40) @(posedge clock);
      check(32'(i_network_partner.frameBytes.size()), 0, "force timer off");
      regOp(1, REG_FORCE, 32'h0000_0005);
      expectFrame('{8'h55}, "force timeout frame");
      sendSer('{8'h66});
      repeat (3) @(posedge clock);
      sendSer('{8'h77});
      expectFrame('{8'h66, 8'h77}, "force timer restarted");
      regOp(1, REG_FORCE, 32'h0000_0000);
      partnerMode <= 2'h1;
      q.delete();
      for (int i = 0; i < BUF_BYTES; i++) q.push_back(8'h20 + 8'(i % 64));
      sendSer(q);
      expectFrame(q, "full buffer frame");
      // Network bytes pile up against a stopped transmitter until refused.
      partnerMode <= 2'h2;
      k = 0;
      netRxValid <= 1'b1;
      netRxData <= 8'hA0;
      repeat (12) begin
         #1;
         took = netRxReady;
         @(posedge clock);
         if (took === 1'b1) begin
            k++;
            netRxData <= 8'hA0 + 8'(k);
         end
      end
      netRxValid <= 1'b0;
      check(32'(k < 12), 1, "network input refused when full");
      partnerMode <= 2'h0;
      repeat (40) @(posedge clock);
      check(32'(i_network_partner.txBytes.size()), 32'(k), "network byte count");
      foreach (i_network_partner.txBytes[i]) check(i_network_partner.txBytes[i], 8'hA0 + 8'(i), "order");
      pulse(0, 4'b0011);
      check({connActive, fullControl, localParams}, 6'b0001_10, "one host only");
      pulse(1, 4'b0001);
      pulse(2, 4'b0001);
      check(connActive, 4'b0000, "single host closed");
      regOp(1, REG_MAXCONN, 32'h0000_0002);
      pulse(0, 4'b0111);
      check({connActive, fullControl, localParams}, 6'b0011_01, "two hosts shared");
      pulse(1, 4'b0010);
      check(serRxReady, 1'b0, "serial halted while closing");
      regOp(0, REG_STATUS, 32'h0000_0000);
      check(rd[ST_SUSPEND], 1'b1, "close pending flag");
      pulse(2, 4'b0010);
      check({serRxReady, connActive}, 5'b1_0001, "serial resumed");
      regOp(1, REG_IDLE, 32'h0000_0001);
      pulse(3, 4'b0001);
      k = 4;
      while (dropLink[0] !== 1'b1 && k < 61000) begin
         @(posedge clock);
         #1;
         k++;
      end
      check(32'(k >= 59995 && k <= 60005), 1, "idle link dropped after one minute");
      repeat (2) @(posedge clock);
      check(connActive, 4'b0000, "idle host gone");
      pulse(0, 4'b0001);
      check(connActive, 4'b0001, "listening again");
      // A reset in mid-run restores the default settings and drops every host.
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      regOp(0, REG_IDLE, 32'h0000_0000);
      check(rd, 32'h0000_0007, "idle timeout after reset");
      check({connActive, fullControl, localParams}, 6'b0000_00, "no host after reset");
      wrapUp();
   end
endmodule
